// file: lp_clock_regs.svh
/*
  Constants of the low-power clock request manager: mode codes, peripheral
  count, field positions and reset values.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef LP_CLOCK_REGS_SVH
`define LP_CLOCK_REGS_SVH
`define NUM_PERIPH        8
`define MODE_RUN          3'h0
`define MODE_SLEEP        3'h1
`define MODE_STOP0        3'h2
`define MODE_STOP1        3'h3
`define MODE_STOP2        3'h4
`define MODE_STANDBY      3'h5
`define SRC_SYS           2'h0
`define SRC_FAST_INT      2'h1
`define SRC_SLOW_EXT      2'h2
`define SRC_SLOW_INT      2'h3
`define SYSSEL_FAST_INT   2'h0
`define SYSSEL_FAST_EXT   2'h1
`define SYSSEL_PLL        2'h2
`define SEC_FAST_INT_BIT  0
`define SEC_FAST_EXT_BIT  1
`define SEC_PLL_BIT       2
`define SEC_SYS_BIT       3
`define PRIV_SEC_BIT      0
`define PRIV_NSEC_BIT     1
`define SEC_CFG_RST       4'h0
`define PRIV_CFG_RST      2'h0
`define SYSSEL_RST        2'h0
`define CFG_FORCE_BIT     0
`define CFG_SYSSEL_LSB    1
`endif

// file: lp_clock_pkg.sv
/*
  Types of the low-power clock request manager.
  Assumes the constants header sits in the same folder.
*/
`include "lp_clock_regs.svh"
package lp_clock_pkg;
  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_SLEEP   = 3'b001,
    ST_STOP0   = 3'b010,
    ST_STOP1   = 3'b011,
    ST_STOP2   = 3'b100,
    ST_STANDBY = 3'b101
  } pmode_t;

  // Per-peripheral configuration, one bit or field per peripheral
  typedef struct packed {
    logic [`NUM_PERIPH-1:0]   clkEn;     // periph_clock_enable_bit
    logic [`NUM_PERIPH-1:0]   sleepEn;   // periph_sleep_clock_enable_bit
    logic [`NUM_PERIPH-1:0]   lowSeg;    // On fourth AHB or seventh APB segment
    logic [`NUM_PERIPH-1:0]   dmaUse;    // Uses the general_dma_engine
    logic [`NUM_PERIPH-1:0]   serial;    // Serial or I2C kind
    logic [2*`NUM_PERIPH-1:0] kerSrc;    // Kernel source, two bits each
  } periph_cfg_t;

  // Requests from the peripherals
  typedef struct packed {
    logic [`NUM_PERIPH-1:0] kerReq;
    logic [`NUM_PERIPH-1:0] busReq;
    logic [`NUM_PERIPH-1:0] irq;
    logic                   dmaDone;
  } periph_req_t;

  // Oscillator and clock gate controls
  typedef struct packed {
    logic fastIntOn;
    logic fastExtOn;
    logic slowExtOn;
    logic slowIntOn;
    logic pllOn;
    logic sysClkOn;
    logic cpuClkOn;
    logic memClkOn;
  } osc_ctl_t;

  // Configuration access from the core
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic       secure;
    logic       priv;
    logic [1:0] sel;    // 0 cfg, 1 security cfg, 2 privilege cfg
    logic [3:0] wdata;
  } cfg_acc_t;
endpackage

// file: sec_cfg_store.sv
/*
  Small store of the protection words: clock_security_config and
  clock_privilege_config. Read data leave a register.
  Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lp_clock_regs.svh"
module sec_cfg_store
  import lp_clock_pkg::*;
(
  input  wire logic       core_clk,   // System clock
  input  wire logic       rst,        // Synchronous reset
  input  wire logic       secWe,      // Write security word
  input  wire logic       privWe,     // Write privilege word
  input  wire logic [3:0] wdata,      // Write data
  output logic      [3:0] secCfg,     // Security word
  output logic      [1:0] privCfg     // Privilege word
);
  logic [3:0] sec_r, sec_nxt;
  logic [1:0] priv_r, priv_nxt;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  always_comb begin
    sec_nxt  = secWe ? wdata : sec_r;
    priv_nxt = privWe ? wdata[1:0] : priv_r;
  end

  // Registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sec_r  <= `SEC_CFG_RST;
      priv_r <= `PRIV_CFG_RST;
    end else begin
      sec_r  <= sec_nxt;
      priv_r <= priv_nxt;
    end
  end

  assign secCfg  = sec_r;
  assign privCfg = priv_r;
endmodule
`default_nettype wire

// file: lp_clock_request_manager.sv
/*
  Low-power clock request manager: tracks the power mode, grants kernel and
  bus clocks to autonomous peripherals, starts and stops oscillators, and
  guards configuration with security and privilege checks.
  Assumes all inputs synchronous to core_clk and oscillator ready flags
  coming from the analog oscillators.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lp_clock_regs.svh"
module lp_clock_request_manager
  import lp_clock_pkg::*;
(
  input  wire logic                   core_clk,      // 250 MHz clock
  input  wire logic                   rst,           // Synchronous reset
  input  wire periph_cfg_t            pcfg,          // Peripheral configuration
  input  wire periph_req_t            preq,          // Peripheral requests
  input  wire logic [2:0]             lpSel,         // Selected low-power mode
  input  wire logic                   sleepReq,      // Core asks for low power
  input  wire logic                   wakeEvt,       // Other wake-up event
  input  wire logic                   flashBusy,     // Flash programming active
  input  wire logic                   apbBusy,       // APB transfer active
  input  wire logic                   secActive,     // Security extension on
  input  wire logic                   fastIntRdy,    // Internal fast osc ready
  input  wire logic                   memGateSw,     // Gate memory clk in Sleep
  input  wire logic [`NUM_PERIPH-1:0] sleepGateSw,   // Gate periph clk in Sleep
  input  wire cfg_acc_t               acc,           // Configuration access
  output pmode_t                      mode,          // Current power mode
  output osc_ctl_t                    osc,           // Oscillator controls
  output logic [`NUM_PERIPH-1:0]      kerGate,       // Kernel clock gates
  output logic [`NUM_PERIPH-1:0]      busGate,       // Bus clock gates
  output logic [1:0]                  sysSel,        // System clock source
  output logic                        forceOn,       // force_internal_osc_kernel_on
  output logic [3:0]                  rdata,         // Configuration read data
  output logic                        accErr         // Refused access pulse
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [`NUM_PERIPH-1:0] srcMask(input logic [2*`NUM_PERIPH-1:0] s,
                                                     input logic [1:0] v);
    logic [`NUM_PERIPH-1:0] m;
    m = '0;
    for (int i = 0; i < `NUM_PERIPH; i++) m[i] = (s[2*i +: 2] == v);
    return m;
  endfunction

  function automatic logic isStop(input pmode_t m);
    return (m == ST_STOP0) || (m == ST_STOP1) || (m == ST_STOP2);
  endfunction

  pmode_t                 mode_r, mode_nxt;
  pmode_t                 ret_r, ret_nxt;       // Mode to return to after bus service
  osc_ctl_t               osc_r, osc_nxt;
  logic [`NUM_PERIPH-1:0] ker_r, ker_nxt, bus_r, bus_nxt;
  logic [1:0]             sys_r, sys_nxt;
  logic                   force_r, force_nxt;
  logic [3:0]             rd_r, rd_nxt;
  logic                   err_r, err_nxt;
  logic [3:0]             secCfg;
  logic [1:0]             privCfg;
  logic                   secWe, privWe, cfgWe;

  // Eligible peripherals: both enables, Stop 2 limits to low segment, no DMA
  logic [`NUM_PERIPH-1:0] auton, fastSel, slowSel, fastKer;
  logic                   anyBus, anyFastKer, anyIrq, holdEntry;
  always_comb begin
    auton = pcfg.clkEn & pcfg.sleepEn;
    // Mask from the entry edge on, so Stop 2 never sees one cycle of wide grants
    if (mode_r == ST_STOP2 || (mode_r == ST_RUN && sleepReq && lpSel == `MODE_STOP2))
      auton = auton & pcfg.lowSeg & ~pcfg.dmaUse;
    fastSel    = srcMask(pcfg.kerSrc, `SRC_FAST_INT);
    slowSel    = srcMask(pcfg.kerSrc, `SRC_SLOW_EXT) | srcMask(pcfg.kerSrc, `SRC_SLOW_INT);
    fastKer    = preq.kerReq & auton & fastSel;
    anyFastKer = |fastKer;
    anyBus     = |(preq.busReq & auton);
    anyIrq     = |(preq.irq & auton);
    holdEntry  = flashBusy | apbBusy;
  end

  // ----------------------------------------
  // Power mode sequencing
  // ----------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    ret_nxt  = ret_r;
    case (mode_r)
      ST_RUN: begin
        if (sleepReq && lpSel == `MODE_SLEEP) mode_nxt = ST_SLEEP;
        else if (sleepReq && !holdEntry) begin
          if (lpSel == `MODE_STOP0) mode_nxt = ST_STOP0;
          else if (lpSel == `MODE_STOP1) mode_nxt = ST_STOP1;
          else if (lpSel == `MODE_STOP2) mode_nxt = ST_STOP2;
          else if (lpSel == `MODE_STANDBY) mode_nxt = ST_STANDBY;
          ret_nxt = mode_nxt;
        end
      end
      ST_SLEEP: begin
        if (wakeEvt || anyIrq) mode_nxt = ST_RUN;
      end
      ST_STOP0, ST_STOP1, ST_STOP2: begin
        if (wakeEvt || anyIrq) mode_nxt = ST_RUN;
        else if (anyBus && mode_r != ST_STOP2) mode_nxt = ST_STOP0;
        else if (!anyBus && (preq.dmaDone || mode_r == ST_STOP0))
          mode_nxt = ret_r;
      end
      ST_STANDBY: begin
        if (wakeEvt) mode_nxt = ST_RUN;
      end
      default: mode_nxt = ST_RUN;
    endcase
  end

  // ----------------------------------------
  // Clock and oscillator control
  // ----------------------------------------
  // Slow oscillators never toggle on demand; a restart would cost long start-up.
  always_comb begin
    osc_nxt           = osc_r;
    ker_nxt           = '0;
    bus_nxt           = '0;
    sys_nxt           = sys_r;
    osc_nxt.slowExtOn = 1'b1;
    osc_nxt.slowIntOn = 1'b1;
    case (mode_nxt)
      ST_RUN: begin
        osc_nxt.sysClkOn = 1'b1;
        osc_nxt.cpuClkOn = 1'b1;
        osc_nxt.memClkOn = 1'b1;
        ker_nxt          = pcfg.clkEn;
        bus_nxt          = pcfg.clkEn;
        if (isStop(mode_r) || mode_r == ST_STANDBY) begin
          osc_nxt.fastIntOn = 1'b1;
          sys_nxt           = `SYSSEL_FAST_INT;
        end
      end
      ST_SLEEP: begin
        osc_nxt.cpuClkOn = 1'b0;
        osc_nxt.memClkOn = !memGateSw;
        ker_nxt          = pcfg.clkEn & pcfg.sleepEn & ~sleepGateSw;
        bus_nxt          = ker_nxt;
      end
      ST_STANDBY: begin
        osc_nxt.sysClkOn  = 1'b0;
        osc_nxt.cpuClkOn  = 1'b0;
        osc_nxt.memClkOn  = 1'b0;
        osc_nxt.pllOn     = 1'b0;
        osc_nxt.fastIntOn = 1'b0;
        osc_nxt.fastExtOn = 1'b0;
      end
      default: begin
        osc_nxt.cpuClkOn  = 1'b0;
        osc_nxt.memClkOn  = 1'b0;
        osc_nxt.pllOn     = 1'b0;
        osc_nxt.fastExtOn = 1'b0;
        osc_nxt.fastIntOn = anyFastKer || anyBus || force_r;
        osc_nxt.sysClkOn  = anyBus && fastIntRdy;
        if (anyBus && fastIntRdy) bus_nxt = auton;
        if (fastIntRdy) ker_nxt = fastKer | (force_r ? auton & fastSel & preq.kerReq : '0);
        ker_nxt = ker_nxt | (preq.kerReq & auton & slowSel);
        sys_nxt = `SYSSEL_FAST_INT;
      end
    endcase
    if (mode_nxt == ST_RUN && cfgWe && acc.wdata[`CFG_FORCE_BIT+1 +: 2] != `SYSSEL_PLL)
      sys_nxt = acc.wdata[`CFG_SYSSEL_LSB +: 2];
    if (mode_nxt == ST_RUN && cfgWe && acc.wdata[`CFG_SYSSEL_LSB +: 2] == `SYSSEL_PLL) begin
      sys_nxt       = `SYSSEL_PLL;
      osc_nxt.pllOn = 1'b1;
    end
  end

  // ----------------------------------------
  // Configuration access with protection
  // ----------------------------------------
  // With secActive set, the security word and a secure system or fast internal item refuse nonsecure traffic; writing the privilege word needs privilege.
  logic secBlock, privBlock;
  always_comb begin
    secBlock  = secActive && !acc.secure && (acc.sel == 2'd0)
                && (secCfg[`SEC_SYS_BIT] || secCfg[`SEC_FAST_INT_BIT]);
    privBlock = (acc.sel == 2'd2 && acc.wrEn && !acc.priv)
              || (acc.sel != 2'd2 && !acc.priv
                  && (acc.secure ? privCfg[`PRIV_SEC_BIT] : privCfg[`PRIV_NSEC_BIT]));
    if (acc.sel == 2'd1 && secActive && !acc.secure) secBlock = 1'b1;
    cfgWe     = acc.wrEn && acc.sel == 2'd0 && !secBlock && !privBlock;
    secWe     = acc.wrEn && acc.sel == 2'd1 && !secBlock && !privBlock;
    privWe    = acc.wrEn && acc.sel == 2'd2 && !secBlock && !privBlock;
    force_nxt = cfgWe ? acc.wdata[`CFG_FORCE_BIT] : force_r;
    err_nxt   = (acc.wrEn || acc.rdEn) && (secBlock || privBlock);
    rd_nxt    = rd_r;
    if (acc.rdEn) begin
      if (secBlock || privBlock) rd_nxt = 4'h0;
      else if (acc.sel == 2'd0) rd_nxt = {1'b0, sys_r, force_r};
      else if (acc.sel == 2'd1) rd_nxt = secCfg;
      else if (acc.sel == 2'd2) rd_nxt = {2'b00, privCfg};
      else rd_nxt = 4'h0;
    end
  end

  sec_cfg_store u_store (
    .core_clk (core_clk),
    .rst      (rst),
    .secWe    (secWe),
    .privWe   (privWe),
    .wdata    (acc.wdata),
    .secCfg   (secCfg),
    .privCfg  (privCfg)
  );

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_r  <= ST_RUN;
      ret_r   <= ST_RUN;
      osc_r   <= '{fastIntOn: 1'b1, fastExtOn: 1'b0, slowExtOn: 1'b1, slowIntOn: 1'b1,
                   pllOn: 1'b0, sysClkOn: 1'b1, cpuClkOn: 1'b1, memClkOn: 1'b1};
      ker_r   <= '0;
      bus_r   <= '0;
      sys_r   <= `SYSSEL_RST;
      force_r <= 1'b0;
      rd_r    <= 4'h0;
      err_r   <= 1'b0;
    end else begin
      mode_r  <= mode_nxt;
      ret_r   <= ret_nxt;
      osc_r   <= osc_nxt;
      ker_r   <= ker_nxt;
      bus_r   <= bus_nxt;
      sys_r   <= sys_nxt;
      force_r <= force_nxt;
      rd_r    <= rd_nxt;
      err_r   <= err_nxt;
    end
  end

  assign mode    = mode_r;
  assign osc     = osc_r;
  assign kerGate = ker_r;
  assign busGate = bus_r;
  assign sysSel  = sys_r;
  assign forceOn = force_r;
  assign rdata   = rd_r;
  assign accErr  = err_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Gates lag requests by one edge, so grants are held against the previous edge
  AST_STOP_NO_PLL: assert property (@(posedge core_clk) disable iff (rst)
    isStop(mode_r) |-> !osc_r.pllOn && !osc_r.fastExtOn) else $error("PLL on in Stop");
  AST_STANDBY_OFF: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == ST_STANDBY |-> !osc_r.fastIntOn && !osc_r.sysClkOn && osc_r.slowExtOn)
    else $error("Standby clocks wrong");
  AST_KER_ONLY_REQ: assert property (@(posedge core_clk) disable iff (rst)
    isStop(mode_r) && isStop($past(mode_r)) |-> (ker_r & ~$past(preq.kerReq)) == '0)
    else $error("Kernel clock to non-requester");
  AST_KER_ENABLED: assert property (@(posedge core_clk) disable iff (rst)
    isStop(mode_r) |-> (ker_r & ~(pcfg.clkEn & pcfg.sleepEn)) == '0 || $changed(pcfg))
    else $error("Kernel clock to disabled peripheral");
  AST_FLASH_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == ST_RUN && flashBusy |=> !isStop(mode_r) && mode_r != ST_STANDBY)
    else $error("Entry during flash programming");
  AST_APB_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == ST_RUN && apbBusy |=> !isStop(mode_r) && mode_r != ST_STANDBY)
    else $error("Entry during APB access");
  AST_IRQ_WAKE: assert property (@(posedge core_clk) disable iff (rst)
    isStop(mode_r) && |(preq.irq & pcfg.clkEn & pcfg.sleepEn & (mode_r == ST_STOP2 ?
      pcfg.lowSeg & ~pcfg.dmaUse : '1)) |=> mode_r == ST_RUN) else $error("No wake on irq");
  AST_WAKE_FAST: assert property (@(posedge core_clk) disable iff (rst)
    $past(isStop(mode_r)) && mode_r == ST_RUN |-> osc_r.fastIntOn && sys_r == `SYSSEL_FAST_INT)
    else $error("Wake clock not fast internal");
  AST_SLEEP_CPU: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == ST_SLEEP |-> !osc_r.cpuClkOn) else $error("CPU clock in Sleep");
  AST_READY_GATE: assert property (@(posedge core_clk) disable iff (rst)
    isStop(mode_r) && osc_r.sysClkOn |-> $past(fastIntRdy)) else $error("Clock before ready");
  AST_PRIV_WRITE: assert property (@(posedge core_clk) disable iff (rst)
    acc.wrEn && acc.sel == 2'd2 && !acc.priv |=> $stable(privCfg)) else $error("Priv write taken");
  // Autonomous service: Stop 2 limits, idle shut-down and return after a transfer
  AST_STOP2_BUS: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == ST_STOP2 |-> (bus_r & ~(pcfg.lowSeg & ~pcfg.dmaUse)) == '0 || $changed(pcfg))
    else $error("Bus clock outside Stop 2 segment");
  AST_SERIAL_STOP2: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == ST_STOP2 && |(preq.kerReq & pcfg.serial & pcfg.clkEn & pcfg.sleepEn
      & pcfg.lowSeg & ~pcfg.dmaUse & srcMask(pcfg.kerSrc, `SRC_FAST_INT))
    |=> osc_r.fastIntOn) else $error("Serial request left oscillator off");
  AST_OSC_IDLE: assert property (@(posedge core_clk) disable iff (rst)
    isStop(mode_r) && !force_r && preq.kerReq == '0 && preq.busReq == '0 && preq.irq == '0
    && !wakeEvt |=> !osc_r.fastIntOn) else $error("Oscillator left on when idle");
  AST_DMA_RETURN: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == ST_STOP0 && preq.dmaDone && preq.busReq == '0 && preq.irq == '0 && !wakeEvt
    |=> mode_r == $past(ret_r) && bus_r == '0 && !osc_r.sysClkOn)
    else $error("No return after transfer");

  // Main scenarios the bench walks through
  COV_STOP0: cover property (@(posedge core_clk) mode_r == ST_STOP0);
  COV_BUS_SERVE: cover property (@(posedge core_clk) mode_r == ST_STOP1 ##1 mode_r == ST_STOP0);
  COV_WAKE: cover property (@(posedge core_clk) isStop(mode_r) ##1 mode_r == ST_RUN);
  COV_REFUSED: cover property (@(posedge core_clk) err_r);
  COV_STOP2_SERIAL: cover property (@(posedge core_clk)
    mode_r == ST_STOP2 && (ker_r & pcfg.serial) != '0);
endmodule
`default_nettype wire

// file: periph_req_model.sv
/*
  Model of the autonomous peripherals and the fast oscillator behind them.
  Assumes commands change just after a rising edge of core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lp_clock_regs.svh"
module periph_req_model
  import lp_clock_pkg::*;
(
  input  wire logic        core_clk, // System clock
  input  wire logic        rst,      // Synchronous reset
  input  wire periph_req_t want,     // Requests to raise
  input  wire logic        oscOn,    // Fast oscillator enable
  output var  periph_req_t preq,     // Requests seen by the manager
  output var  logic        oscRdy    // Fast oscillator ready
);
  logic [1:0] warm_r;
  // ----------------
  // Requests
  // ----------------
  // Ready lags the enable by two cycles, so a gate opened early shows up
  always_ff @(posedge core_clk) begin
    if (rst) begin
      preq   <= '0;
      warm_r <= 2'h0;
    end else begin
      preq   <= want;
      warm_r <= oscOn ? {warm_r[0], 1'b1} : 2'h0;
    end
  end
  assign oscRdy = warm_r[1];
endmodule
`default_nettype wire

// file: lowpower_clock_request_manager_tb_top.sv
/*
  Bench of the clock request manager: mode table, then requests, busy hold
  and access protection. Assumes the package and the model file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lp_clock_regs.svh"
module lowpower_clock_request_manager_tb_top
  import lp_clock_pkg::*;
;
  typedef struct packed {logic [2:0] sel; logic [7:0] msk; logic [7:0] exp;} row_t;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        sleepReq = 1'b0;
  logic        wakeEvt = 1'b0;
  logic        flashBusy = 1'b0;
  logic        apbBusy = 1'b0;
  logic        secActive = 1'b0;
  logic        memGateSw = 1'b0;
  logic [7:0]  sleepGateSw = 8'h00;
  logic        fastIntRdy;
  logic [2:0]  lpSel = 3'h0;
  periph_cfg_t pcfg = '{clkEn:8'h03, sleepEn:8'h01, serial:8'h01, kerSrc:16'h0005,
                        default:'0};
  periph_req_t preq;
  periph_req_t want = '0;
  cfg_acc_t    acc = '0;
  pmode_t      mode;
  osc_ctl_t    osc;
  logic [7:0]  kerGate;
  logic [7:0]  busGate;
  logic [3:0]  rdata;
  logic [1:0]  sysSel;
  logic        forceOn;
  logic        accErr;
  int          compares = 0;
  int          mismatches = 0;
  int          cycles = 0;
  row_t        rows [5] = '{'{3'h1, 8'h06, 8'h04}, '{3'h2, 8'hfc, 8'h30},
                            '{3'h3, 8'hfc, 8'h30}, '{3'h4, 8'hfc, 8'h30},
                            '{3'h5, 8'hfc, 8'h30}};

  lp_clock_request_manager u_lp_clock_request_manager (
    .core_clk(core_clk), .rst(rst), .pcfg(pcfg), .preq(preq), .lpSel(lpSel),
    .sleepReq(sleepReq), .wakeEvt(wakeEvt), .flashBusy(flashBusy), .apbBusy(apbBusy),
    .secActive(secActive), .fastIntRdy(fastIntRdy), .memGateSw(memGateSw),
    .sleepGateSw(sleepGateSw), .acc(acc), .mode(mode), .osc(osc), .kerGate(kerGate),
    .busGate(busGate), .sysSel(sysSel), .forceOn(forceOn), .rdata(rdata),
    .accErr(accErr));
  periph_req_model u_periph_req_model (.core_clk(core_clk), .rst(rst), .want(want),
    .oscOn(osc.fastIntOn), .preq(preq), .oscRdy(fastIntRdy));

  // ----------------
  // Helpers
  // ----------------
  always #2 core_clk = ~core_clk;

  // A hang is cut short well past the hundred-odd cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic enter(input logic [2:0] m);
    @(posedge core_clk);
    lpSel    <= m;
    sleepReq <= 1'b1;
    @(posedge core_clk);
    sleepReq <= 1'b0;
    @(posedge core_clk) #1;
  endtask

  task automatic wake();
    @(posedge core_clk);
    wakeEvt <= 1'b1;
    @(posedge core_clk);
    wakeEvt <= 1'b0;
    @(posedge core_clk) #1;
  endtask

  task automatic access(input logic wr, sec, pv, input logic [1:0] s, input logic [3:0] d);
    @(posedge core_clk);
    acc <= '{wrEn:wr, rdEn:~wr, secure:sec, priv:pv, sel:s, wdata:d};
    @(posedge core_clk);
    acc <= '0;
    #1;
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------
  // Tests
  // ----------------
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk) #1;
    chk("mode", 8'h00, 8'(mode));
    chk("fastIntOn", 8'h01, 8'(osc.fastIntOn));
    $display("reset test done");
    foreach (rows[i]) begin
      enter(rows[i].sel);
      chk("mode", 8'(rows[i].sel), 8'(mode));
      chk("osc", rows[i].exp, 8'(osc) & rows[i].msk);
      wake();
      chk("sysSel", 8'h00, 8'(sysSel));
      $display("mode row %0d done", i);
    end
    // Software gating of memory and peripheral clocks in Sleep
    @(posedge core_clk);
    memGateSw   <= 1'b1;
    sleepGateSw <= 8'h01;
    enter(3'h1);
    chk("memClkOn", 8'h00, 8'(osc.memClkOn));
    chk("kerGate", 8'h00, kerGate);
    wake();
    @(posedge core_clk);
    memGateSw   <= 1'b0;
    sleepGateSw <= 8'h00;
    $display("sleep gating test done");
    // Bus request from Stop 1, closed by a finished transfer
    enter(3'h3);
    @(posedge core_clk);
    want.busReq <= 8'h03;
    repeat (12) if (mode !== ST_STOP0) @(posedge core_clk) #1;
    chk("mode", 8'(ST_STOP0), 8'(mode));
    chk("busGate", 8'h00, busGate);
    chk("fastIntOn", 8'h01, 8'(osc.fastIntOn));
    repeat (12) if (busGate !== 8'h01) @(posedge core_clk) #1;
    chk("busGate", 8'h01, busGate);
    chk("sysClkOn", 8'h01, 8'(osc.sysClkOn));
    @(posedge core_clk);
    want <= '{dmaDone:1'b1, default:'0};
    repeat (12) if (mode !== ST_STOP1) @(posedge core_clk) #1;
    chk("mode", 8'(ST_STOP1), 8'(mode));
    chk("fastIntOn", 8'h00, 8'(osc.fastIntOn));
    $display("bus test done");
    @(posedge core_clk);
    want <= '{kerReq:8'h03, default:'0};
    repeat (12) if (kerGate !== 8'h01) @(posedge core_clk) #1;
    chk("kerGate", 8'h01, kerGate);
    chk("fastIntOn", 8'h01, 8'(osc.fastIntOn));
    @(posedge core_clk);
    want <= '0;
    repeat (12) if (osc.fastIntOn !== 1'b0) @(posedge core_clk) #1;
    chk("fastIntOn", 8'h00, 8'(osc.fastIntOn));
    chk("kerGate", 8'h00, kerGate);
    @(posedge core_clk);
    want <= '{irq:8'h01, default:'0};
    repeat (12) if (mode !== ST_RUN) @(posedge core_clk) #1;
    chk("mode", 8'(ST_RUN), 8'(mode));
    @(posedge core_clk);
    want <= '0;
    enter(3'h4);
    @(posedge core_clk);
    want <= '{busReq:8'h01, default:'0};
    repeat (6) @(posedge core_clk) #1;
    chk("mode", 8'(ST_STOP2), 8'(mode));
    chk("busGate", 8'h00, busGate);
    chk("fastIntOn", 8'h00, 8'(osc.fastIntOn));
    @(posedge core_clk);
    pcfg.lowSeg <= 8'h01;
    want        <= '{kerReq:8'h01, busReq:8'h01, default:'0};
    repeat (12) if (kerGate !== 8'h01) @(posedge core_clk) #1;
    chk("kerGate", 8'h01, kerGate);
    chk("busGate", 8'h01, busGate);
    chk("mode", 8'(ST_STOP2), 8'(mode));
    @(posedge core_clk);
    want        <= '0;
    pcfg.lowSeg <= 8'h00;
    wake();
    $display("kernel test done");
    // Entry held by flash, then by the peripheral bus
    @(posedge core_clk);
    flashBusy <= 1'b1;
    lpSel     <= 3'h3;
    sleepReq  <= 1'b1;
    repeat (4) @(posedge core_clk) #1;
    chk("mode", 8'(ST_RUN), 8'(mode));
    @(posedge core_clk);
    flashBusy <= 1'b0;
    apbBusy   <= 1'b1;
    repeat (4) @(posedge core_clk) #1;
    chk("mode", 8'(ST_RUN), 8'(mode));
    @(posedge core_clk);
    apbBusy <= 1'b0;
    @(posedge core_clk);
    sleepReq <= 1'b0;
    #1;
    chk("mode", 8'(ST_STOP1), 8'(mode));
    wake();
    $display("busy test done");
    access(1'b1, 1'b1, 1'b1, 2'h0, 4'h1);
    chk("forceOn", 8'h01, 8'(forceOn));
    enter(3'h3);
    chk("fastIntOn", 8'h01, 8'(osc.fastIntOn));
    wake();
    access(1'b1, 1'b1, 1'b1, 2'h0, 4'h0);
    @(posedge core_clk);
    secActive <= 1'b1;
    access(1'b1, 1'b1, 1'b1, 2'h1, 4'h1);
    access(1'b0, 1'b1, 1'b1, 2'h1, 4'h0);
    chk("rdata", 8'h01, 8'(rdata));
    chk("accErr", 8'h00, 8'(accErr));
    access(1'b0, 1'b0, 1'b1, 2'h0, 4'h0);
    chk("accErr", 8'h01, 8'(accErr));
    chk("rdata", 8'h00, 8'(rdata));
    access(1'b1, 1'b1, 1'b0, 2'h2, 4'h3);
    chk("accErr", 8'h01, 8'(accErr));
    access(1'b0, 1'b1, 1'b1, 2'h2, 4'h0);
    chk("rdata", 8'h00, 8'(rdata));
    $display("access test done");
    results();
  end
endmodule
`default_nettype wire
